// ---- rtl/module_mgmt_status_timing.sv ----
module module_mgmt_status_timing #(
  parameter int INIT_CYCLES_P = mgmt_pkg::INIT_CYCLES,
  parameter int RESET_MIN_P = mgmt_pkg::RESET_MIN_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic MODULE_RESET_N,
  input wire logic MODULE_SELECT_N,
  input wire logic LOW_POWER_REQUEST,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire mgmt_pkg::cond_s CONDITION,
  output logic INTERRUPT_REQUEST_N,
  output logic LOW_POWER
);

  localparam int IW = $clog2(INIT_CYCLES_P + 1);
  localparam int RW = $clog2(RESET_MIN_P + 1);
  if (INIT_CYCLES_P < 1 || RESET_MIN_P < 1)
  begin : g_bad_param
    $error("counts must be at least one cycle");
  end

  // -------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------
  logic [mgmt_pkg::SYNC_W-1:0] sync1, sync2, raw;
  assign raw = {MODULE_RESET_N, MODULE_SELECT_N, SCL, SDA_IN, LOW_POWER_REQUEST, CONDITION};

  genvar gs;
  for (gs = 0; gs < mgmt_pkg::SYNC_W; gs++)
  begin : g_sync
    always_ff @(posedge CLOCK)
    begin
      if (!RST_N)
      begin
        sync1[gs] <= mgmt_pkg::SYNC_RESET[gs];
        sync2[gs] <= mgmt_pkg::SYNC_RESET[gs];
      end
      else
      begin
        sync1[gs] <= raw[gs];
        sync2[gs] <= sync1[gs];
      end
    end
  end

  mgmt_pkg::cond_s cond;
  logic lp_req, sda_s, scl_s, sel_n_s, mr_n_s;
  assign {mr_n_s, sel_n_s, scl_s, sda_s, lp_req, cond} = sync2;

  // -------------------------------------------------------------
  // module reset pulse filter
  // -------------------------------------------------------------
  logic [RW-1:0] low_cnt;
  logic module_rst, srst;
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N || mr_n_s)
      low_cnt <= '0;
    else if (low_cnt != RW'(RESET_MIN_P))
      low_cnt <= low_cnt + 1'b1;
  end

  // only a low level that outlasts the minimum pulse counts as a reset
  assign module_rst = (low_cnt == RW'(RESET_MIN_P));
  assign srst = !RST_N || module_rst;

  // -------------------------------------------------------------
  // apb slave
  // -------------------------------------------------------------
  logic fw_ready, apb_wr, apb_setup_rd, mapped, ready, int_act;
  logic [3:0] event_set;
  logic [31:0] apb_word;
  logic [3:0] flags [mgmt_pkg::NUM_GROUPS];
  logic [3:0] masks [mgmt_pkg::NUM_GROUPS];
  assign mapped = (PADDR == mgmt_pkg::APB_CTRL) || (PADDR == mgmt_pkg::APB_EVENT)
               || (PADDR == mgmt_pkg::APB_STATUS) || (PADDR == mgmt_pkg::APB_MASK);
  assign apb_wr = PSEL && PENABLE && PWRITE && mapped;
  assign apb_setup_rd = PSEL && !PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  always_comb
  begin
    apb_word = '0;
    case (PADDR)
      mgmt_pkg::APB_CTRL: apb_word[mgmt_pkg::CTRL_READY_BIT] = fw_ready;
      mgmt_pkg::APB_STATUS:
      begin
        apb_word[mgmt_pkg::ST_READY_BIT-1:0] = {flags[2], flags[1], flags[0]};
        apb_word[mgmt_pkg::ST_READY_BIT] = ready;
        apb_word[mgmt_pkg::ST_INT_BIT] = int_act;
        apb_word[mgmt_pkg::ST_LP_BIT] = LOW_POWER;
      end
      mgmt_pkg::APB_MASK: apb_word[mgmt_pkg::ST_READY_BIT-1:0] = {masks[2], masks[1], masks[0]};
      default: apb_word = '0;
    endcase
  end

  // read data is captured in the setup cycle so the access phase needs no wait
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      PRDATA <= '0;
    else if (apb_setup_rd)
      PRDATA <= apb_word;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      fw_ready <= 1'b0;
    else if (apb_wr && PADDR == mgmt_pkg::APB_CTRL)
      fw_ready <= PWDATA[mgmt_pkg::CTRL_READY_BIT];
  end
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N || !(apb_wr && PADDR == mgmt_pkg::APB_EVENT))
      event_set <= '0;
    else
      event_set <= PWDATA[3:0];
  end

  // -------------------------------------------------------------
  // initialisation
  // -------------------------------------------------------------
  logic [IW-1:0] init_cnt;
  logic init_done, init_flag, status_clr;
  // firmware may declare monitor data ready early; the timer is the backstop
  assign init_done = (init_cnt == IW'(INIT_CYCLES_P - 1)) || fw_ready;

  always_ff @(posedge CLOCK)
  begin
    if (srst)
      init_cnt <= '0;
    else if (!ready)
      init_cnt <= init_cnt + 1'b1;
  end

  always_ff @(posedge CLOCK)
  begin
    if (srst)
      ready <= 1'b0;
    else if (init_done)
      ready <= 1'b1;
  end

  // the ready transition raises the interrupt; reading status byte 2 clears it
  always_ff @(posedge CLOCK)
  begin
    if (srst)
      init_flag <= 1'b0;
    else
      init_flag <= (!ready && init_done) || (init_flag && !status_clr);
  end

  // -------------------------------------------------------------
  // 2-wire slave
  // -------------------------------------------------------------
  mgmt_pkg::link_state_e state;
  logic scl_d, sda_d, scl_rise, scl_fall, start_det, stop_det, selected;
  logic rw, rd_load, wr_strobe;
  logic [3:0] bitcnt;
  logic [7:0] shift, tx, ptr, rd_byte;
  logic [1:0] pwr_ctl;
  function automatic logic byte_hit(input logic [7:0] addr, input logic [7:0] base,
                                    input int g);
    byte_hit = (addr == base + 8'(g));
  endfunction

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det = scl_s && scl_d && !sda_d && sda_s;
  assign selected = !sel_n_s;
  assign wr_strobe = scl_fall && state == mgmt_pkg::S_WR && bitcnt == mgmt_pkg::BITS_PER_BYTE;
  assign rd_load = scl_fall && ((state == mgmt_pkg::S_DEV_ACK && rw)
                 || state == mgmt_pkg::S_RD_ACK);
  assign status_clr = rd_load && ptr == mgmt_pkg::STATUS_BYTE;

  always_comb
  begin
    rd_byte = '0;
    if (ptr == mgmt_pkg::STATUS_BYTE)
      rd_byte[mgmt_pkg::NOT_READY_BIT] = !ready;
    if (ptr == mgmt_pkg::CONTROL_BYTE)
      rd_byte = {6'h00, pwr_ctl};
    for (int g = 0; g < mgmt_pkg::NUM_GROUPS; g++)
    begin
      if (byte_hit(ptr, mgmt_pkg::FLAG_BASE, g))
        rd_byte = {4'h0, flags[g]};
      if (byte_hit(ptr, mgmt_pkg::MASK_BASE, g))
        rd_byte = {4'h0, masks[g]};
    end
  end

  // bits are sampled on scl rise and the data line moves only after scl falls
  always_ff @(posedge CLOCK)
  begin
    if (srst)
    begin
      state <= mgmt_pkg::S_IDLE;
      bitcnt <= '0;
      shift <= '0;
      tx <= '0;
      ptr <= '0;
      rw <= 1'b0;
      SDA_OE <= 1'b0;
    end
    else if (!selected || stop_det)
    begin
      state <= mgmt_pkg::S_IDLE;
      SDA_OE <= 1'b0;
    end
    else if (start_det)
    begin
      state <= mgmt_pkg::S_DEV;
      bitcnt <= '0;
      SDA_OE <= 1'b0;
    end
    else
    begin
      case (state)
        mgmt_pkg::S_DEV, mgmt_pkg::S_REG, mgmt_pkg::S_WR:
        begin
          if (scl_rise)
          begin
            shift <= {shift[6:0], sda_s};
            bitcnt <= bitcnt + 1'b1;
          end
          else if (scl_fall && bitcnt == mgmt_pkg::BITS_PER_BYTE)
          begin
            bitcnt <= '0;
            SDA_OE <= 1'b1;
            if (state == mgmt_pkg::S_DEV)
            begin
              if (shift[7:1] == mgmt_pkg::DEV_ADDR)
              begin
                rw <= shift[0];
                state <= mgmt_pkg::S_DEV_ACK;
              end
              else
              begin
                SDA_OE <= 1'b0;
                state <= mgmt_pkg::S_IDLE;
              end
            end
            else if (state == mgmt_pkg::S_REG)
            begin
              ptr <= shift;
              state <= mgmt_pkg::S_REG_ACK;
            end
            else
            begin
              ptr <= ptr + 1'b1;
              state <= mgmt_pkg::S_WR_ACK;
            end
          end
        end
        mgmt_pkg::S_DEV_ACK, mgmt_pkg::S_REG_ACK, mgmt_pkg::S_WR_ACK, mgmt_pkg::S_RD_ACK:
        begin
          // a not-acknowledge ends a read; an acknowledge loads the next byte
          if (state == mgmt_pkg::S_RD_ACK && scl_rise && sda_s)
            state <= mgmt_pkg::S_IDLE;
          else if (rd_load)
          begin
            tx <= rd_byte;
            ptr <= ptr + 1'b1;
            SDA_OE <= !rd_byte[7];
            bitcnt <= '0;
            state <= mgmt_pkg::S_RD;
          end
          else if (scl_fall)
          begin
            SDA_OE <= 1'b0;
            state <= (state == mgmt_pkg::S_DEV_ACK) ? mgmt_pkg::S_REG : mgmt_pkg::S_WR;
          end
        end
        mgmt_pkg::S_RD:
        begin
          if (scl_rise)
            bitcnt <= bitcnt + 1'b1;
          else if (scl_fall && bitcnt == mgmt_pkg::BITS_PER_BYTE)
          begin
            SDA_OE <= 1'b0;
            state <= mgmt_pkg::S_RD_ACK;
          end
          else if (scl_fall)
          begin
            tx <= {tx[6:0], 1'b0};
            SDA_OE <= !tx[6];
          end
        end
        default: state <= mgmt_pkg::S_IDLE;
      endcase
    end
  end

  // open drain: the line is only ever pulled low
  assign SDA_OUT = 1'b0;

  // -------------------------------------------------------------
  // masks and power control
  // -------------------------------------------------------------
  // writes take effect at the acknowledge of each data byte, well ahead of
  // the stop bit, so any bound counted from after the stop is met
  always_ff @(posedge CLOCK)
  begin
    if (srst)
      pwr_ctl <= '0;
    else if (wr_strobe && ptr == mgmt_pkg::CONTROL_BYTE)
      pwr_ctl <= shift[1:0];
  end

  genvar gm;
  for (gm = 0; gm < mgmt_pkg::NUM_GROUPS; gm++)
  begin : g_mask
    always_ff @(posedge CLOCK)
    begin
      if (srst)
        masks[gm] <= '0;
      else if (wr_strobe && byte_hit(ptr, mgmt_pkg::MASK_BASE, gm))
        masks[gm] <= shift[mgmt_pkg::LANES-1:0];
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      LOW_POWER <= 1'b0;
    else if (pwr_ctl[mgmt_pkg::OVERRIDE_BIT])
      LOW_POWER <= pwr_ctl[mgmt_pkg::POWER_SET_BIT];
    else
      LOW_POWER <= lp_req;
  end

  // -------------------------------------------------------------
  // latched flags and interrupt
  // -------------------------------------------------------------
  logic [3:0] set_v [mgmt_pkg::NUM_GROUPS];
  assign set_v[0] = cond.los;
  assign set_v[1] = cond.tx_fault;
  assign set_v[2] = cond.other | event_set;

  genvar gf;
  for (gf = 0; gf < mgmt_pkg::NUM_GROUPS; gf++)
  begin : g_flag
    logic clr;
    assign clr = rd_load && byte_hit(ptr, mgmt_pkg::FLAG_BASE, gf);
    // a condition still present at the clearing read sets the flag again
    always_ff @(posedge CLOCK)
    begin
      if (srst)
        flags[gf] <= '0;
      else
        flags[gf] <= set_v[gf] | (flags[gf] & {mgmt_pkg::LANES{!clr}});
    end
  end

  assign int_act = init_flag || |((flags[0] & ~masks[0]) | (flags[1] & ~masks[1])
                 | (flags[2] & ~masks[2]));

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      INTERRUPT_REQUEST_N <= 1'b1;
    else
      INTERRUPT_REQUEST_N <= !int_act;
  end

endmodule

// ---- rtl/mgmt_pkg.sv ----
// How it works
// - module becomes fully functional at most 2000 ms after power-on, hot plug or reset release
// - a module reset low for longer than 2 us resets the module
// - the 2-wire bus answers within 2000 ms of power-on
// - within 2000 ms data-not-ready (status byte 2 bit 0) clears and interrupt asserts
// - after module reset rises, fully functional within 2000 ms
// - low power request high enters low power within 100 us
// - an interrupt condition drives the interrupt low within 200 ms
// - receive loss of signal sets its flag and interrupt within 100 ms
// - transmit fault sets its flag and interrupt within 200 ms
// - any other condition sets its flag and interrupt within 200 ms
// - setting a mask bit inhibits its interrupt within 100 ms
// - clearing a mask bit resumes its interrupt within 100 ms
// - after module select asserts, bus transactions are answered within 100 us
// - after module select deasserts, bus transactions are ignored within 100 us
// - power override set enters low power within 100 ms
// - power override cleared returns to full function within 300 ms
// - write-started delays count from the clock fall after the stop bit
// - fully functional means interrupt asserted because data-not-ready cleared
// - the 2-wire device address is 1010000 plus the read/write bit
package mgmt_pkg;

  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int T_INIT_MS = 2000;
  localparam int INIT_CYCLES = T_INIT_MS * (CLK_HZ / 1000);
  localparam int T_RESET_MIN_US = 2;
  localparam int RESET_MIN_CYCLES = (T_RESET_MIN_US * CLK_HZ + 999_999) / 1_000_000;

  // -------------------------------------------------------------
  // 2-wire map
  // -------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic [7:0] STATUS_BYTE = 8'h02;
  localparam logic [7:0] FLAG_BASE = 8'h03;
  localparam logic [7:0] CONTROL_BYTE = 8'h5D;
  localparam logic [7:0] MASK_BASE = 8'h64;
  localparam int NUM_GROUPS = 3;
  localparam int LANES = 4;
  localparam int NOT_READY_BIT = 0;
  localparam int OVERRIDE_BIT = 0;
  localparam int POWER_SET_BIT = 1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // -------------------------------------------------------------
  // apb map
  // -------------------------------------------------------------
  localparam logic [11:0] APB_CTRL = 12'h000;
  localparam logic [11:0] APB_EVENT = 12'h004;
  localparam logic [11:0] APB_STATUS = 12'h008;
  localparam logic [11:0] APB_MASK = 12'h00C;
  localparam int CTRL_READY_BIT = 0;
  localparam int ST_READY_BIT = 12;
  localparam int ST_INT_BIT = 13;
  localparam int ST_LP_BIT = 14;

  // synchroniser reset levels: reset_n, select_n, scl, sda idle high
  localparam int SYNC_W = 17;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 17'h1E000;

  typedef struct packed {
    logic [3:0] other;
    logic [3:0] tx_fault;
    logic [3:0] los;
  } cond_s;

  typedef enum logic [8:0] {
    S_IDLE    = 9'h001,
    S_DEV     = 9'h002,
    S_DEV_ACK = 9'h004,
    S_REG     = 9'h008,
    S_REG_ACK = 9'h010,
    S_WR      = 9'h020,
    S_WR_ACK  = 9'h040,
    S_RD      = 9'h080,
    S_RD_ACK  = 9'h100
  } link_state_e;

endpackage

// ---- test/mgmt_status_asserts.sv ----
module mgmt_status_asserts #(
  parameter int INIT_CYCLES_P = 200,
  parameter int RESET_MIN_P = 8
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic MODULE_RESET_N,
  input wire logic MODULE_SELECT_N,
  input wire logic LOW_POWER_REQUEST,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic INTERRUPT_REQUEST_N,
  input wire logic LOW_POWER
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  logic mapped;
  logic seen;
  int init_cnt;
  int low_cnt;
  int lp_cnt;
  assign mapped = PADDR inside {mgmt_pkg::APB_CTRL, mgmt_pkg::APB_EVENT,
                                mgmt_pkg::APB_STATUS, mgmt_pkg::APB_MASK};
  // ----
  // helper counters
  // ----
  // a short module reset pulse also restarts the wait and clears seen; the module does not reinitialise, so no new interrupt meets the bound
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N || !MODULE_RESET_N)
    begin
      init_cnt <= 0;
      seen <= 1'b0;
    end
    else
    begin
      if (!seen)
        init_cnt <= init_cnt + 1;
      if (!INTERRUPT_REQUEST_N)
        seen <= 1'b1;
    end
  end
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N || MODULE_RESET_N)
      low_cnt <= 0;
    else if (low_cnt < 1000)
      low_cnt <= low_cnt + 1;
  end
  // how long a low power request has waited; 4000 cycles is 100 us at 40 MHz
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N || !LOW_POWER_REQUEST || LOW_POWER)
      lp_cnt <= 0;
    else if (lp_cnt < 5000)
      lp_cnt <= lp_cnt + 1;
  end
  // ----
  // properties
  // ----
  pready_high_a: assert property (PSEL && PENABLE |-> PREADY)
    else $error("pready low in access phase");
  slverr_decode_a: assert property (PSLVERR == (PSEL && PENABLE && !mapped))
    else $error("slave error does not match address decode");
  unmapped_read_a: assert property (PSEL && !PENABLE && !PWRITE && !mapped |=> PRDATA == 32'h0)
    else $error("unmapped read returned data");
  reset_values_a: assert property ($rose(RST_N) |-> INTERRUPT_REQUEST_N && !LOW_POWER && !SDA_OE)
    else $error("outputs not at reset values");
  init_bound_a: assert property (seen || init_cnt <= INIT_CYCLES_P + 10)
    else $error("interrupt not raised after initialisation");
  module_reset_a: assert property (low_cnt > RESET_MIN_P + 6 |-> INTERRUPT_REQUEST_N && !SDA_OE)
    else $error("module not held in reset");
  low_power_a: assert property (lp_cnt <= 4000)
    else $error("low power not entered in time");
  deselect_quiet_a: assert property (MODULE_SELECT_N [*8] |-> !SDA_OE)
    else $error("deselected module drives the data line");
  open_drain_a: assert property (!SDA_OUT)
    else $error("data line driven high");
  cover property (init_cnt > 0 && $fell(INTERRUPT_REQUEST_N));
  cover property ($rose(LOW_POWER));
  cover property (PSLVERR);
  cover property ($rose(SDA_OE));
endmodule

bind module_mgmt_status_timing mgmt_status_asserts #(
  .INIT_CYCLES_P(INIT_CYCLES_P),
  .RESET_MIN_P(RESET_MIN_P)
) checker_i (
  .CLOCK(CLOCK),
  .RST_N(RST_N),
  .PSEL(PSEL),
  .PENABLE(PENABLE),
  .PWRITE(PWRITE),
  .PADDR(PADDR),
  .PRDATA(PRDATA),
  .PREADY(PREADY),
  .PSLVERR(PSLVERR),
  .MODULE_RESET_N(MODULE_RESET_N),
  .MODULE_SELECT_N(MODULE_SELECT_N),
  .LOW_POWER_REQUEST(LOW_POWER_REQUEST),
  .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE),
  .INTERRUPT_REQUEST_N(INTERRUPT_REQUEST_N),
  .LOW_POWER(LOW_POWER)
);

// ---- test/mgmt_host.sv ----
module mgmt_host (
  input wire logic clk,
  input wire logic sda_oe,
  input wire logic sda_out,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hold_low = 1'b0;
  // wired-and with a pull-up: a released line reads high, never the last value
  assign sda = !(hold_low || (sda_oe && !sda_out));
  initial scl = 1'b1;
  // ----
  // bit level, 8 clocks per bit
  // ----
  // data moves one clock after the fall so it never looks like a start or stop
  task automatic bit_time(input logic low, output logic line);
    @(posedge clk);
    hold_low <= low;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    line = sda;
    scl <= 1'b0;
  endtask
  task automatic edge_pair(input logic first, input logic second);
    @(posedge clk);
    hold_low <= first;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    hold_low <= second;
    repeat (4) @(posedge clk);
  endtask
  task automatic start();
    edge_pair(1'b0, 1'b1);
    scl <= 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      bit_time(!d[i], q[i]);
    bit_time(1'b0, b);
    ack = !b;
  endtask
  // ----
  // transfers
  // ----
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] v,
                          output logic ack);
    logic [7:0] q;
    logic a0, a1, a2, nak;
    start();
    xbyte({dev, 1'b0}, q, a0);
    xbyte(ptr, q, a1);
    start();
    xbyte({dev, 1'b1}, q, a2);
    xbyte(8'hFF, v, nak);
    edge_pair(1'b1, 1'b0);
    ack = a0 & a1 & a2;
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
                           output logic ack);
    logic [7:0] q;
    logic a0, a1, a2;
    start();
    xbyte({dev, 1'b0}, q, a0);
    xbyte(ptr, q, a1);
    xbyte(d, q, a2);
    edge_pair(1'b1, 1'b0);
    ack = a0 & a1 & a2;
  endtask
endmodule

// ---- test/module_mgmt_status_timing_test.sv ----
module module_mgmt_status_timing_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INIT_P = 200;
  localparam int RMIN_P = 8;
  localparam logic [6:0] DEV = mgmt_pkg::DEV_ADDR;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, scl, sda, sda_out, sda_oe, irq_n, low_power;
  logic module_reset_n = 1'b1;
  logic module_select_n = 1'b0;
  logic low_power_request = 1'b0;
  mgmt_pkg::cond_s condition = '0;
  mgmt_pkg::cond_s c;
  logic [31:0] q;
  logic [7:0] v;
  logic e, ack;
  int error_cnt = 0;
  int compares = 0;
  int seed = 44503;
  int lane;
  initial forever #12.5 clock = ~clock;
  module_mgmt_status_timing #(.INIT_CYCLES_P(INIT_P), .RESET_MIN_P(RMIN_P)) uut (
    .CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .MODULE_RESET_N(module_reset_n), .MODULE_SELECT_N(module_select_n),
    .LOW_POWER_REQUEST(low_power_request), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .CONDITION(condition), .INTERRUPT_REQUEST_N(irq_n),
    .LOW_POWER(low_power)
  );
  mgmt_host host (.clk(clock), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda(sda));
  // ----
  // helpers
  // ----
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // sel 0 watches the interrupt pin, sel 1 the power level
  task automatic wait_lvl(input logic sel, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((sel ? low_power : irq_n) !== lvl && n < lim)
    begin
      @(posedge clock);
      n++;
    end
    check(sel ? low_power : irq_n, lvl);
  endtask
  function automatic logic [31:0] st_exp(mgmt_pkg::cond_s f, logic rdy, logic irq, logic lp);
    return {17'h0, lp, irq, rdy, f};
  endfunction
  // ----
  // sequence
  // ----
  initial
  begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, mgmt_pkg::APB_STATUS, 32'h0);
    check(q, st_exp('0, 1'b0, 1'b0, 1'b0));
    wait_lvl(1'b0, 1'b0, INIT_P + 20);
    apb(1'b0, mgmt_pkg::APB_STATUS, 32'h0);
    check(q, st_exp('0, 1'b1, 1'b1, 1'b0));
    host.read_reg(DEV, mgmt_pkg::STATUS_BYTE, v, ack);
    check({ack, v[0]}, 2'b10);
    wait_lvl(1'b0, 1'b1, 20000);
    module_select_n <= 1'b1;
    host.read_reg(DEV, mgmt_pkg::STATUS_BYTE, v, ack);
    check(ack, 1'b0);
    module_select_n <= 1'b0;
    host.read_reg(DEV ^ (7'h1 << ($unsigned($random(seed)) % 7)), 8'h02, v, ack);
    check(ack, 1'b0);
    host.read_reg(DEV, mgmt_pkg::STATUS_BYTE, v, ack);
    check(ack, 1'b1);
    for (int g = 0; g < 3; g++)
    begin
      lane = $unsigned($random(seed)) % 4;
      c = '0;
      c[g * 4 + lane] = 1'b1;
      condition <= c;
      wait_lvl(1'b0, 1'b0, 200);
      apb(1'b0, mgmt_pkg::APB_STATUS, 32'h0);
      check(q, st_exp(c, 1'b1, 1'b1, 1'b0));
      condition <= '0;
      host.read_reg(DEV, mgmt_pkg::FLAG_BASE + 8'(g), v, ack);
      check(v, 8'h1 << lane);
      wait_lvl(1'b0, 1'b1, 20000);
    end
    lane = $unsigned($random(seed)) % 4;
    c = '0;
    c.los[lane] = 1'b1;
    host.write_reg(DEV, mgmt_pkg::MASK_BASE, 8'h1 << lane, ack);
    apb(1'b0, mgmt_pkg::APB_MASK, 32'h0);
    check(q, {20'h0, c});
    condition <= c;
    repeat (40) @(posedge clock);
    check(irq_n, 1'b1);
    host.write_reg(DEV, mgmt_pkg::MASK_BASE, 8'h00, ack);
    wait_lvl(1'b0, 1'b0, 4000);
    // a condition that persists re-sets its flag, so the pin stays active
    host.read_reg(DEV, mgmt_pkg::FLAG_BASE, v, ack);
    repeat (40) @(posedge clock);
    check(irq_n, 1'b0);
    condition <= '0;
    host.read_reg(DEV, mgmt_pkg::FLAG_BASE, v, ack);
    wait_lvl(1'b0, 1'b1, 20000);
    c = '0;
    c.other = 4'($unsigned($random(seed))) | 4'h1;
    apb(1'b1, mgmt_pkg::APB_EVENT, {28'h0, c.other});
    wait_lvl(1'b0, 1'b0, 200);
    apb(1'b0, mgmt_pkg::APB_STATUS, 32'h0);
    check(q, st_exp(c, 1'b1, 1'b1, 1'b0));
    host.read_reg(DEV, mgmt_pkg::FLAG_BASE + 8'h2, v, ack);
    check(v, {4'h0, c.other});
    wait_lvl(1'b0, 1'b1, 20000);
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    check(e, 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    check(q, 32'h0);
    low_power_request <= 1'b1;
    wait_lvl(1'b1, 1'b1, 4000);
    low_power_request <= 1'b0;
    wait_lvl(1'b1, 1'b0, 4000);
    host.write_reg(DEV, mgmt_pkg::CONTROL_BYTE, 8'h03, ack);
    wait_lvl(1'b1, 1'b1, 4000);
    host.write_reg(DEV, mgmt_pkg::CONTROL_BYTE, 8'h00, ack);
    wait_lvl(1'b1, 1'b0, 12000);
    module_reset_n <= 1'b0;
    repeat (RMIN_P + 8) @(posedge clock);
    apb(1'b0, mgmt_pkg::APB_STATUS, 32'h0);
    check(q, st_exp('0, 1'b0, 1'b0, 1'b0));
    module_reset_n <= 1'b1;
    wait_lvl(1'b0, 1'b0, INIT_P + 20);
    results();
  end
  // whole run is a few thousand cycles; this span leaves wide headroom
  initial
  begin
    #2_000_000;
    error_cnt++;
    results();
  end
endmodule
